//--- include/flash_row_defines.vh
// Purpose: constants for the flash row write latch controller
// Assumes: 14-bit flash words, 32 latches per row, 15-bit word address
// Notes:   definitions only
`ifndef FLASH_ROW_DEFINES_VH
`define FLASH_ROW_DEFINES_VH

`define FR_WORD_W        14
`define FR_ADDR_W        15
`define FR_LATCH_N       32
`define FR_LATCH_IDX_W   5
// used bits of the high address byte and of the high data byte
`define FR_ADRH_USED     7
`define FR_DATH_USED     6
`define FR_ROW_W         10
`define FR_BLANK_WORD    14'h3fff
`define FR_UNLOCK_KEY1   8'h55
`define FR_UNLOCK_KEY2   8'haa
`define FR_ADDR_ZERO     15'h0000
`define FR_DATA_ZERO     14'h0000
// alternate region address map
`define FR_UID_LO        15'h0000
`define FR_UID_HI        15'h0003
`define FR_ID_LO         15'h0005
`define FR_ID_HI         15'h0006
`define FR_CFG_LO        15'h0007
`define FR_CFG_HI        15'h000b
`define FR_INFO_LO       15'h0100
`define FR_INFO_HI       15'h02ff
`define FR_EE_LO         15'h7000
`define FR_EE_HI         15'h70ff
// programming timer, in ns
`define FR_PROG_TIME_NS  2000
`define FR_CLK_PERIOD_NS 10

`endif

//--- rtl/flash_row_write_latch_controller.v
// Purpose: self-programming sequencer for program flash rows with 32 write latches
// Assumes: software writes control bits through the plain ports below, one clock domain
// Notes:   the flash array sits outside; its busy/done handshake is prog_start/array_done
//          reads are not taken while a row operation is busy
`include "flash_row_defines.vh"
`timescale 1ns/100ps
`default_nettype none

// Operation
// - row is address bits [14:5]; latch index is address bits [4:0].
// - latch loads and row operations stay inside the one addressed row.
// - all latches return to 0x3FFF when any program or erase completes.
// - start with erase-select erases whole row, ignores latch-only and data.
// - start with latch-only copies data into latch outside the alternate region, ignores protection.
// - start with neither programs all latches into addressed row.
// - protected erase or write clears start bit, sets error, no change.
// - error flag set on protected start, reset mid-write, broken unlock.
// - error flag software settable, cleared only by software; here sys_rst also clears it.
// - no load or program unless full unbroken unlock precedes start.
// - at most 32 words per operation, any subset allowed.
// - alternate region map: ids/config writable, identity and info read-only.
// - alternate read outside valid ranges clears data pair to zero.
// - completion sets done flag; interrupt when both enables are set.
// - instruction fetch halts while a row write or erase runs.
module flash_row_write_latch_controller #(
  parameter PROG_CYCLES = (`FR_PROG_TIME_NS + `FR_CLK_PERIOD_NS - 1) / `FR_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire                       clk_sys,
  input  wire                       sys_rst,
  // control bits written by software
  input  wire [7:0]                 flash_address_high_byte,
  input  wire [7:0]                 flash_address_low_byte,
  input  wire [7:0]                 flash_data_high_byte,
  input  wire [7:0]                 flash_data_low_byte,
  input  wire                       program_erase_permit,
  input  wire                       alternate_region_select,
  input  wire                       latch_only_select,
  input  wire                       erase_select,
  input  wire                       write_start_set,
  input  wire                       read_start_set,
  input  wire                       unlock_write,
  input  wire [7:0]                 unlock_data,
  input  wire                       other_access,
  input  wire                       error_set,
  input  wire                       error_clear,
  input  wire                       done_flag_clear,
  input  wire                       flash_done_interrupt_enable,
  input  wire                       global_interrupt_enable,
  input  wire                       reset_during_write,
  // write protection, decided outside for the main array
  input  wire                       write_protect,
  // flash array side
  input  wire [`FR_WORD_W-1:0]      array_read_data,
  input  wire                       array_done,
  output reg                        prog_start_ff,
  output reg                        prog_erase_ff,
  output reg                        prog_region_ff,
  output reg  [`FR_ROW_W-1:0]       prog_row_ff,
  output wire [`FR_WORD_W*`FR_LATCH_N-1:0] latch_image,
  // status back to software
  output reg                        write_start_ff,
  output reg                        write_error_flag_ff,
  output reg                        flash_done_interrupt_flag_ff,
  output wire                       flash_irq,
  output wire                       fetch_halt,
  output reg  [`FR_WORD_W-1:0]      read_data_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  function in_range;
    input [`FR_ADDR_W-1:0] a;
    input [`FR_ADDR_W-1:0] lo;
    input [`FR_ADDR_W-1:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  // bit 7 of the high address byte does not exist in the word address
  wire [`FR_ADDR_W-1:0]      addr_pair = {flash_address_high_byte[`FR_ADRH_USED-1:0],
                                          flash_address_low_byte};

  wire [`FR_ROW_W-1:0]       row_sel   = addr_pair[`FR_ADDR_W-1:`FR_LATCH_IDX_W];
  wire [`FR_LATCH_IDX_W-1:0] latch_sel = addr_pair[`FR_LATCH_IDX_W-1:0];

  // a flash word is fourteen bits; the top two bits of the high data byte are dropped
  wire [`FR_WORD_W-1:0]      data_pair = {flash_data_high_byte[`FR_DATH_USED-1:0],
                                          flash_data_low_byte};

  wire in_user_id    = in_range(addr_pair, `FR_UID_LO, `FR_UID_HI);
  wire in_ident      = in_range(addr_pair, `FR_ID_LO, `FR_ID_HI);
  wire in_config     = in_range(addr_pair, `FR_CFG_LO, `FR_CFG_HI);
  wire in_info       = in_range(addr_pair, `FR_INFO_LO, `FR_INFO_HI);
  wire in_data_store = in_range(addr_pair, `FR_EE_LO, `FR_EE_HI);

  // identity words and the info area can be read but never written
  wire alt_writable = in_user_id || in_config || in_data_store;
  wire alt_readable = alt_writable || in_ident || in_info;

  // main array protection comes from outside; the alternate region uses the map
  wire protected_addr = alternate_region_select ? !alt_writable : write_protect;

  ////////////////////////////////////////////////////////////////////////////
  // unlock sequence tracker
  // first key seen, then both keys seen; the start must come in the very next cycle
  localparam UL_IDLE = 2'b00;
  localparam UL_KEY1 = 2'b01;
  localparam UL_ARMED = 2'b10;

  reg [1:0] unlock_state_ff;
  reg [1:0] nxt_unlock_state;
  reg       unlock_broken;

  // both key steps decode the unlock write in the same way
  function key_match;
    input       wr;
    input [7:0] data;
    input [7:0] key;
    begin
      key_match = wr && (data == key);
    end
  endfunction

  wire key1_seen = key_match(unlock_write, unlock_data, `FR_UNLOCK_KEY1);
  wire key2_seen = key_match(unlock_write, unlock_data, `FR_UNLOCK_KEY2);

  always @* begin
    nxt_unlock_state = unlock_state_ff;
    unlock_broken    = 1'b0;
    case (unlock_state_ff)
      UL_IDLE: begin
        if (key1_seen)
          nxt_unlock_state = UL_KEY1;
      end
      UL_KEY1: begin
        // any cycle after the first key that is not the second key breaks the sequence
        if (key2_seen) begin
          nxt_unlock_state = UL_ARMED;
        end else begin
          nxt_unlock_state = UL_IDLE;
          unlock_broken    = 1'b1;
        end
      end
      UL_ARMED: begin
        // a missing start here counts as an interrupted sequence
        nxt_unlock_state = UL_IDLE;
        unlock_broken    = !write_start_set;
      end
      default: nxt_unlock_state = UL_IDLE;
    endcase
  end

  // only an armed start acts
  // starts while busy are dropped quietly; they are not reported as errors
  // latch loads aimed at the alternate region are ignored
  wire start_ok = write_start_set && (unlock_state_ff == UL_ARMED) &&
                  program_erase_permit && !write_start_ff;
  wire do_latch = start_ok && !erase_select && latch_only_select && !alternate_region_select;
  wire do_row   = start_ok && (erase_select || !latch_only_select);
  wire row_refused = do_row && protected_addr;
  wire row_go      = do_row && !protected_addr;

  ////////////////////////////////////////////////////////////////////////////
  // write latches
  reg  [`FR_WORD_W-1:0] latch_ff [0:`FR_LATCH_N-1];
  reg  [31:0]           timer_ff;

  // the count only sets a floor; the array's own done ends the operation
  wire                  timer_at_last = (timer_ff == 32'd1);
  wire                  timer_end     = write_start_ff && timer_at_last && array_done;

  // the array always takes the whole row image; unloaded words stay blank

  genvar gi;
  generate
    for (gi = 0; gi < `FR_LATCH_N; gi = gi + 1) begin : g_latch
      // index of this latch, sized like the low address bits
      localparam [`FR_LATCH_IDX_W-1:0] LATCH_IDX = gi;

      always @(posedge clk_sys) begin
        if (sys_rst || timer_end) begin
          latch_ff[gi] <= `FR_BLANK_WORD;
        end else if (do_latch && latch_sel == LATCH_IDX) begin
          latch_ff[gi] <= data_pair;
        end
      end

      assign latch_image[gi*`FR_WORD_W +: `FR_WORD_W] = latch_ff[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and timer
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      unlock_state_ff <= UL_IDLE;
      write_start_ff  <= 1'b0;
      timer_ff        <= 32'd0;
      prog_start_ff   <= 1'b0;
      prog_erase_ff   <= 1'b0;
      prog_region_ff  <= 1'b0;
      prog_row_ff     <= {`FR_ROW_W{1'b0}};
    end else begin
      unlock_state_ff <= nxt_unlock_state;
      prog_start_ff   <= 1'b0;
      if (row_go) begin
        write_start_ff <= 1'b1;
        timer_ff       <= PROG_CYCLES;
        prog_start_ff  <= 1'b1;
        prog_erase_ff  <= erase_select;
        prog_region_ff <= alternate_region_select;
        prog_row_ff    <= row_sel;
      end else if (write_start_ff) begin
        // a count below two still waits for the array to report done
        if (timer_ff > 32'd1) begin
          timer_ff <= timer_ff - 32'd1;
        end else if (array_done) begin
          write_start_ff <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error flag, done flag, read data
  // error sources
  // a refused row start, a broken unlock, or a device reset seen while busy
  wire err_protect = row_refused;
  wire err_unlock  = unlock_broken;
  wire err_reset   = reset_during_write && write_start_ff;
  wire err_event   = err_protect || err_unlock || err_reset;


  always @(posedge clk_sys) begin
    if (sys_rst) begin
      write_error_flag_ff          <= 1'b0;
      flash_done_interrupt_flag_ff <= 1'b0;
      read_data_ff                 <= `FR_DATA_ZERO;
    end else begin
      if (err_event || error_set) begin
        write_error_flag_ff <= 1'b1;
      end else if (error_clear) begin
        write_error_flag_ff <= 1'b0;
      end

      // done flag on completion
      // set wins over the clear so that a completion is never lost
      if (timer_end) begin
        flash_done_interrupt_flag_ff <= 1'b1;
      end else if (done_flag_clear) begin
        flash_done_interrupt_flag_ff <= 1'b0;
      end

      // invalid alternate read gives zero
      // the array cannot be read while it programs, so busy reads are dropped
      if (read_start_set && !write_start_ff) begin
        read_data_ff <= (alternate_region_select && !alt_readable) ?
                        `FR_DATA_ZERO : array_read_data;
      end
    end
  end

  assign flash_irq  = flash_done_interrupt_flag_ff && flash_done_interrupt_enable &&
                      global_interrupt_enable;
  assign fetch_halt = write_start_ff;


  // spare input for a bus access monitor; it does not affect the sequencer
  wire unused_ok = other_access;

endmodule // flash_row_write_latch_controller

`default_nettype wire

//--- verification/flash_array_model.sv
// Purpose: far-side program flash array with its programming timer
// Assumes: timer starts on each prog_start_ff pulse
// Notes:   slow selects a long timer so busy is seen to stretch
`timescale 1ns/100ps
`default_nettype none
module flash_array_model (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        prog_start_ff,
  input  wire logic        prog_erase_ff,
  input  wire logic [447:0] latch_image,
  input  wire logic [7:0]  flash_address_low_byte,
  input  wire logic        slow,
  output logic             array_done,
  output logic [13:0]      array_read_data
);
  logic [3:0] wait_ff;
  always_ff @(posedge clk_sys) begin
    if (sys_rst || prog_start_ff) wait_ff <= slow ? 4'hc : 4'h1;
    else if (wait_ff != 4'h0) wait_ff <= wait_ff - 4'h1;
  end
  // done is a level until the next start
  assign array_done = (wait_ff == 4'h0) && !prog_start_ff;
  // one row image for every row; reads pick a word by the low address bits
  logic [447:0] row_ff;
  // programming only clears bits, there is no automatic erase
  always_ff @(posedge clk_sys) begin
    if (sys_rst) row_ff <= {32{14'h1a5c}};
    else if (prog_start_ff && prog_erase_ff) row_ff <= {448{1'b1}};
    else if (prog_start_ff) row_ff <= row_ff & latch_image;
  end
  assign array_read_data = row_ff[14*flash_address_low_byte[4:0] +: 14];
endmodule // flash_array_model
`default_nettype wire

//--- verification/flash_row_write_latch_controller_props.sv
// Purpose: port-level properties of the row write sequencer
// Assumes: single clock domain, synchronous reset
// Notes:   only ports of the top module are watched
`timescale 1ns/100ps
`default_nettype none
module flash_row_props (
  input wire logic         clk_sys,
  input wire logic         sys_rst,
  input wire logic         unlock_write,
  input wire logic [7:0]   unlock_data,
  input wire logic         write_start_set,
  input wire logic         program_erase_permit,
  input wire logic         alternate_region_select,
  input wire logic         latch_only_select,
  input wire logic         write_protect,
  input wire logic         error_set,
  input wire logic         error_clear,
  input wire logic         prog_start_ff,
  input wire logic         write_start_ff,
  input wire logic         fetch_halt,
  input wire logic         write_error_flag_ff,
  input wire logic         flash_done_interrupt_flag_ff,
  input wire logic [447:0] latch_image
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_start_needs_key: assert property ($rose(prog_start_ff) |-> $past(write_start_set)
    && $past(unlock_write, 2) && $past(unlock_data, 2) == 8'haa
    && $past(unlock_data, 3) == 8'h55 && $past(program_erase_permit)) else $error("unkeyed start");
  a_prog_one_cycle: assert property (prog_start_ff |=> !prog_start_ff)
    else $error("start pulse too long");
  a_busy_with_start: assert property (prog_start_ff |-> write_start_ff && fetch_halt)
    else $error("busy missing at start");
  a_busy_min_time: assert property ($rose(write_start_ff)
    |-> write_start_ff[*2] ##[1:40] !write_start_ff) else $error("busy length wrong");
  a_done_sets_flag: assert property ($fell(write_start_ff)
    |-> flash_done_interrupt_flag_ff) else $error("done flag not set");
  a_blank_after_op: assert property ($fell(write_start_ff)
    |-> latch_image == {32{14'h3fff}}) else $error("latches not blank");
  a_error_sticky: assert property (write_error_flag_ff && !error_clear
    |=> write_error_flag_ff) else $error("error flag lost");
  a_error_by_sw: assert property (error_set |=> write_error_flag_ff)
    else $error("error flag not set");
  a_protect_no_op: assert property (write_start_set && write_protect
    && !latch_only_select && !alternate_region_select |=> !prog_start_ff)
    else $error("protected start");
endmodule // flash_row_props
bind flash_row_write_latch_controller flash_row_props u_props (.*);
`default_nettype wire

//--- verification/flash_row_write_latch_controller_tb.sv
// Purpose: self-checking bench for the row write sequencer
// Assumes: inputs change at the falling edge
// Notes:   short programming timer keeps the run brief
`include "flash_row_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module flash_row_write_latch_controller_tb;
  logic clk_sys = 0, sys_rst = 1, slow = 0, array_done, other_access = 0;
  logic [7:0] flash_address_high_byte = '0, flash_address_low_byte = '0, unlock_data = '0;
  logic [7:0] flash_data_high_byte = '0, flash_data_low_byte = '0;
  logic program_erase_permit = 1, alternate_region_select = 0, latch_only_select = 0;
  logic erase_select = 0, write_start_set = 0, read_start_set = 0, unlock_write = 0;
  logic error_set = 0, error_clear = 0, done_flag_clear = 0, reset_during_write = 0;
  logic flash_done_interrupt_enable = 1, global_interrupt_enable = 1, write_protect = 0;
  logic prog_start_ff, prog_erase_ff, prog_region_ff, write_start_ff, fetch_halt;
  logic write_error_flag_ff, flash_done_interrupt_flag_ff, flash_irq;
  logic [9:0] prog_row_ff;
  logic [13:0] array_read_data, read_data_ff;
  logic [447:0] latch_image, exp;
  localparam logic [447:0] BLANK = {32{`FR_BLANK_WORD}};
  int errors = 0, checks = 0, cyc_n = 0;
  flash_row_write_latch_controller #(.PROG_CYCLES(3)) DUT (.*);
  flash_array_model u_far (.*);
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      errors++;
      finish_test;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [447:0] got, input logic [447:0] want);
    checks++;
    if (got !== want) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    @(negedge clk_sys) s = 0;
  endtask
  // 55h, second key, then start on consecutive cycles
  task automatic unlock_go(input logic [7:0] k2);
    unlock_write = 1;
    unlock_data = 8'h55;
    @(negedge clk_sys) unlock_data = k2;
    @(negedge clk_sys) unlock_write = 0;
    pulse(write_start_set);
  endtask
  task automatic load(input logic [15:0] a, input logic [15:0] d);
    {flash_address_high_byte, flash_address_low_byte} = a;
    {flash_data_high_byte, flash_data_low_byte} = d;
    unlock_go(8'haa);
  endtask
  task automatic wait_idle;
    repeat (40) if (write_start_ff === 1'b1) @(negedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic sc_program;
    exp = BLANK;
    exp[14*31 +: 14] = 14'h1234;
    exp[13:0] = 14'h0abc;
    flash_address_low_byte = 8'h3f;
    pulse(read_start_set);
    chk(read_data_ff, 14'h1a5c);
    {erase_select, latch_only_select} = 2'h3;
    load(16'h0120, 16'h0000);
    wait_idle;
    erase_select = 0;
    latch_only_select = 1;
    write_protect = 1;
    load(16'h013f, 16'h1234);
    load(16'h0120, 16'h0abc);
    chk(latch_image, exp);
    {latch_only_select, write_protect, slow} = 3'h1;
    load(16'h0125, 16'h3333);
    chk({fetch_halt, prog_start_ff, prog_erase_ff, prog_row_ff}, 13'h1809);
    wait_idle;
    chk({flash_irq, flash_done_interrupt_flag_ff, latch_image}, {2'h3, BLANK});
    flash_done_interrupt_enable = 0;
    #1 chk({flash_irq, flash_done_interrupt_flag_ff}, 2'h1);
    flash_done_interrupt_enable = 1;
    pulse(done_flag_clear);
    chk({flash_irq, flash_done_interrupt_flag_ff}, 2'h0);
    flash_address_low_byte = 8'h20;
    pulse(read_start_set);
    chk(read_data_ff, 14'h0abc);
    flash_address_low_byte = 8'h3f;
    pulse(read_start_set);
    chk(read_data_ff, 14'h1234);
  endtask
  task automatic sc_erase;
    {erase_select, latch_only_select, slow} = 3'h6;
    load(16'h0240, 16'h1111);
    chk({prog_start_ff, prog_erase_ff, prog_row_ff}, 12'hc12);
    pulse(reset_during_write);
    chk(write_error_flag_ff, 1'h1);
    wait_idle;
    chk(latch_image, BLANK);
    pulse(error_clear);
    chk(write_error_flag_ff, 1'h0);
  endtask
  task automatic sc_faults;
    {erase_select, latch_only_select, write_protect} = 3'h1;
    load(16'h0300, 16'h2222);
    chk({write_start_ff, write_error_flag_ff}, 2'h1);
    pulse(error_clear);
    {write_protect, latch_only_select} = 2'h1;
    unlock_go(8'h00);
    chk({write_error_flag_ff, latch_image}, {1'h1, BLANK});
    pulse(error_clear);
    pulse(write_start_set);
    chk({write_error_flag_ff, latch_image}, {1'h0, BLANK});
    pulse(error_set);
    repeat (5) @(negedge clk_sys);
    chk(write_error_flag_ff, 1'h1);
    pulse(error_clear);
    chk(write_error_flag_ff, 1'h0);
    program_erase_permit = 0;
    load(16'h0301, 16'h0123);
    chk({write_error_flag_ff, latch_image}, {1'h0, BLANK});
    program_erase_permit = 1;
  endtask
  task automatic sc_alt;
    {alternate_region_select, latch_only_select, erase_select} = 3'h5;
    {flash_address_high_byte, flash_address_low_byte} = 16'h0005;
    pulse(read_start_set);
    chk(read_data_ff, 14'h3fff);
    flash_address_low_byte = 8'h04;
    pulse(read_start_set);
    chk(read_data_ff, 14'h0000);
    load(16'h0006, 16'h0000);
    chk({write_start_ff, write_error_flag_ff}, 2'h1);
    pulse(error_clear);
    load(16'h0002, 16'h0000);
    chk({prog_start_ff, prog_region_ff}, 2'h3);
    wait_idle;
  endtask
  task automatic finish_test;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk_sys);
    sys_rst = 0;
    sc_program;
    sc_erase;
    sc_faults;
    sc_alt;
    finish_test;
  end
endmodule // flash_row_write_latch_controller_tb
`default_nettype wire
